// *** rtl/pmtb_pkg.sv ***
// package: register map, field positions and reset values of the master time bases
package pmtb_pkg;
    // register offsets (word index on the plain register port)
    localparam logic [3:0] PTB_CTRL_OFS  = 4'h0;
    localparam logic [3:0] PTB_DIV_OFS   = 4'h1;
    localparam logic [3:0] PTB_PER_OFS   = 4'h2;
    localparam logic [3:0] PTB_CMP_OFS   = 4'h3;
    localparam logic [3:0] STB_CTRL_OFS  = 4'h4;
    localparam logic [3:0] STB_DIV_OFS   = 4'h5;
    localparam logic [3:0] STB_PER_OFS   = 4'h6;
    localparam logic [3:0] STB_CMP_OFS   = 4'h7;
    localparam logic [3:0] CHOP_OFS      = 4'h8;
    localparam logic [3:0] PCNT_OFS      = 4'h9;
    localparam logic [3:0] SCNT_OFS      = 4'hA;
    // control register fields
    localparam int MOD_ON_BIT   = 15;
    localparam int PEND_BIT     = 12;
    localparam int IRQ_ON_BIT   = 11;
    localparam int UPD_NOW_BIT  = 10;
    localparam int POL_BIT      = 9;
    localparam int SOUT_BIT     = 8;
    localparam int XSYNC_BIT    = 7;
    localparam int SRC_LSB      = 4;
    localparam int PS_LSB       = 0;
    localparam int CHOP_ON_BIT  = 15;
    localparam int CHOP_DIV_LSB = 3;
    // writable masks and reset values
    localparam logic [15:0] PCTRL_MASK = 16'hAFFF;
    localparam logic [15:0] SCTRL_MASK = 16'h0FFF;
    localparam logic [15:0] CMP_MASK   = 16'hFFF8;
    localparam logic [15:0] CHOP_MASK  = 16'h83F8;
    localparam logic [15:0] PER_RESET  = 16'hFFF8;
    localparam logic [2:0]  DIV_RESET  = 3'h0;
    localparam logic [2:0]  DIV_MAX    = 3'h6;
    localparam logic [2:0]  SRC_MAX    = 3'h3;
endpackage : pmtb_pkg

// *** rtl/pmtb_core.sv ***
// master time bases: prescalers, period counters, event triggers, sync and chop clock
module pmtb_core (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic [3:0]  sync_input_n,
    output logic             primary_sync_out,
    output logic             secondary_sync_out,
    output logic             primary_trigger,
    output logic             secondary_trigger,
    output logic             secondary_irq,
    output logic             chop_clk,
    output logic      [15:0] primary_master_counter,
    output logic      [15:0] secondary_master_counter
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [2:0]  div;
        logic [15:0] per_buf;
        logic [15:0] per_act;
        logic [15:0] cmp;
        logic [5:0]  pre;
        logic [15:0] cnt;
        logic [3:0]  post;
        logic        trig;
        logic        sout;
        logic [1:0]  sedge;
    } pmtb_tb_t;

    typedef struct packed {
        pmtb_tb_t [1:0] tb;
        logic [15:0]    chop;
        logic [3:0]     sync_m;
        logic [3:0]     sync_s;
        logic [9:0]     chop_cnt;
        logic           chop_clk;
        logic           pend;
        logic [15:0]    rdata;
    } pmtb_state_t;

    pmtb_state_t st;
    pmtb_state_t next_st;

    // ticks of each prescaler: divide by 2**code, reserved code never ticks
    logic [1:0] tick;
    logic [1:0] match;
    logic [1:0] wrap;
    logic [1:0] sync_hit;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_tb
            logic [5:0] lim;
            logic       pol;
            logic       sel_lvl;
            assign lim = 6'((7'd1 << st.tb[g].div) - 7'd1);
            assign tick[g] = st.tb[0].ctrl[pmtb_pkg::MOD_ON_BIT]
                             && (st.tb[g].div <= pmtb_pkg::DIV_MAX)
                             && (st.tb[g].pre == lim);
            assign match[g] = tick[g] && (st.tb[g].cnt == st.tb[g].cmp);
            assign wrap[g] = tick[g] && (st.tb[g].cnt >= st.tb[g].per_act);
            assign pol = st.tb[g].ctrl[pmtb_pkg::POL_BIT];
            // source code above 3 is reserved and selects nothing
            assign sel_lvl = (st.tb[g].ctrl[pmtb_pkg::SRC_LSB +: 3] <= pmtb_pkg::SRC_MAX)
                ? st.sync_s[st.tb[g].ctrl[pmtb_pkg::SRC_LSB +: 2]] ^ pol : 1'b0;
            assign sync_hit[g] = st.tb[g].ctrl[pmtb_pkg::XSYNC_BIT]
                                 && (st.tb[g].sedge == 2'b01);
        end
    endgenerate

    // sync edge detector input, kept in state per time base
    logic [1:0] sel_now;
    assign sel_now[0] = gen_tb[0].sel_lvl;
    assign sel_now[1] = gen_tb[1].sel_lvl;

    // last count of a half period, 8*(div+1) ticks: ten bits so every divider code fits
    logic [9:0] chop_lim;
    assign chop_lim = {st.chop[pmtb_pkg::CHOP_DIV_LSB +: 7], 3'h7};

    // next-state logic for bus, time bases and chop generator
    always_comb begin
        logic [15:0] rd;
        logic        ev_set;
        rd = 16'h0000;
        ev_set = 1'b0;
        next_st = st;
        next_st.sync_m = sync_input_n;
        next_st.sync_s = st.sync_m;
        for (int i = 0; i < 2; i++) begin
            next_st.tb[i].trig = 1'b0;
            next_st.tb[i].sedge = {st.tb[i].sedge[0], sel_now[i]};
            if (!st.tb[0].ctrl[pmtb_pkg::MOD_ON_BIT]) begin
                next_st.tb[i].pre = 6'h00;
                next_st.tb[i].cnt = 16'h0000;
                next_st.tb[i].post = 4'h0;
            end else if (sync_hit[i]) begin
                next_st.tb[i].pre = 6'h00;
                next_st.tb[i].cnt = 16'h0000;
            end else if (tick[i]) begin
                next_st.tb[i].pre = 6'h00;
                next_st.tb[i].cnt = wrap[i] ? 16'h0000 : st.tb[i].cnt + 16'h0001;
                if (wrap[i]) begin
                    next_st.tb[i].per_act = st.tb[i].per_buf;
                end
            end else begin
                next_st.tb[i].pre = st.tb[i].pre + 6'h01;
            end
            if (match[i]) begin
                // postscaler counts matches, trigger on the last of each group
                if (st.tb[i].post == st.tb[i].ctrl[pmtb_pkg::PS_LSB +: 4]) begin
                    next_st.tb[i].post = 4'h0;
                    next_st.tb[i].trig = 1'b1;
                end else begin
                    next_st.tb[i].post = st.tb[i].post + 4'h1;
                end
            end
            // sync out pulses for one clock at each period wrap; a sync restart alone gives no pulse
            next_st.tb[i].sout = (st.tb[i].ctrl[pmtb_pkg::SOUT_BIT] && wrap[i])
                ^ st.tb[i].ctrl[pmtb_pkg::POL_BIT];
        end
        ev_set = next_st.tb[1].trig;
        // register writes; postscaler and sync fields assumed static while running
        if (reg_wr) begin
            unique case (reg_addr)
                pmtb_pkg::PTB_CTRL_OFS: next_st.tb[0].ctrl = reg_wdata & pmtb_pkg::PCTRL_MASK;
                pmtb_pkg::STB_CTRL_OFS: next_st.tb[1].ctrl = reg_wdata & pmtb_pkg::SCTRL_MASK;
                pmtb_pkg::PTB_DIV_OFS:  next_st.tb[0].div = reg_wdata[2:0];
                pmtb_pkg::STB_DIV_OFS:  next_st.tb[1].div = reg_wdata[2:0];
                pmtb_pkg::PTB_PER_OFS: begin
                    next_st.tb[0].per_buf = reg_wdata;
                    if (st.tb[0].ctrl[pmtb_pkg::UPD_NOW_BIT])
                        next_st.tb[0].per_act = reg_wdata;
                end
                pmtb_pkg::STB_PER_OFS: begin
                    next_st.tb[1].per_buf = reg_wdata;
                    if (st.tb[1].ctrl[pmtb_pkg::UPD_NOW_BIT])
                        next_st.tb[1].per_act = reg_wdata;
                end
                pmtb_pkg::PTB_CMP_OFS: next_st.tb[0].cmp = reg_wdata & pmtb_pkg::CMP_MASK;
                pmtb_pkg::STB_CMP_OFS: next_st.tb[1].cmp = reg_wdata & pmtb_pkg::CMP_MASK;
                pmtb_pkg::CHOP_OFS:    next_st.chop = reg_wdata & pmtb_pkg::CHOP_MASK;
                default: ;
            endcase
        end
        // pending flag: hardware sets on trigger, hardware clears when irq disabled
        if (ev_set)
            next_st.pend = 1'b1;
        else if (!next_st.tb[1].ctrl[pmtb_pkg::IRQ_ON_BIT] || !st.tb[0].ctrl[pmtb_pkg::MOD_ON_BIT])
            next_st.pend = 1'b0;
        // chop: toggle every 8*(div+1) primary ticks, full period 16*(div+1)
        if (!st.chop[pmtb_pkg::CHOP_ON_BIT] || !st.tb[0].ctrl[pmtb_pkg::MOD_ON_BIT]) begin
            next_st.chop_cnt = 10'h000;
            next_st.chop_clk = 1'b0;
        end else if (tick[0]) begin
            if (st.chop_cnt == chop_lim) begin
                next_st.chop_cnt = 10'h000;
                next_st.chop_clk = ~st.chop_clk;
            end else begin
                next_st.chop_cnt = st.chop_cnt + 10'h001;
            end
        end
        // read mux, unmapped addresses read zero
        unique case (reg_addr)
            pmtb_pkg::PTB_CTRL_OFS: rd = st.tb[0].ctrl;
            pmtb_pkg::STB_CTRL_OFS: rd = {st.tb[1].ctrl[15:13], st.pend, st.tb[1].ctrl[11:0]};
            pmtb_pkg::PTB_DIV_OFS:  rd = {13'h0000, st.tb[0].div};
            pmtb_pkg::STB_DIV_OFS:  rd = {13'h0000, st.tb[1].div};
            pmtb_pkg::PTB_PER_OFS:  rd = st.tb[0].per_buf;
            pmtb_pkg::STB_PER_OFS:  rd = st.tb[1].per_buf;
            pmtb_pkg::PTB_CMP_OFS:  rd = st.tb[0].cmp;
            pmtb_pkg::STB_CMP_OFS:  rd = st.tb[1].cmp;
            pmtb_pkg::CHOP_OFS:     rd = st.chop;
            pmtb_pkg::PCNT_OFS:     rd = st.tb[0].cnt;
            pmtb_pkg::SCNT_OFS:     rd = st.tb[1].cnt;
            default:                rd = 16'h0000;
        endcase
        next_st.rdata = reg_rd ? rd : 16'h0000;
    end

    // single state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.tb[0].per_buf <= pmtb_pkg::PER_RESET;
            st.tb[0].per_act <= pmtb_pkg::PER_RESET;
            st.tb[1].per_buf <= pmtb_pkg::PER_RESET;
            st.tb[1].per_act <= pmtb_pkg::PER_RESET;
            st.tb[0].div <= pmtb_pkg::DIV_RESET;
            st.tb[1].div <= pmtb_pkg::DIV_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign primary_sync_out = st.tb[0].sout;
    assign secondary_sync_out = st.tb[1].sout;
    assign primary_trigger = st.tb[0].trig;
    assign secondary_trigger = st.tb[1].trig;
    assign secondary_irq = st.pend && st.tb[1].ctrl[pmtb_pkg::IRQ_ON_BIT];
    assign chop_clk = st.chop_clk;
    assign primary_master_counter = st.tb[0].cnt;
    assign secondary_master_counter = st.tb[1].cnt;

    // compare registers keep their low three bits at zero
    chk_cmp_low_zero: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.tb[0].cmp[2:0] == 3'h0 && st.tb[1].cmp[2:0] == 3'h0)
        else $error("compare low bits not zero");

    // counter walks zero to period one tick at a time
    chk_cnt_wrap: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        wrap[0] && !sync_hit[0] |=> primary_master_counter == 16'h0000)
        else $error("primary counter did not restart");
    chk_cnt_step: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.tb[0].ctrl[15] && tick[0] && !wrap[0] && !sync_hit[0]
        |=> primary_master_counter == $past(primary_master_counter) + 16'h0001)
        else $error("primary counter skipped a step");

    // module off freezes both bases at zero and drops pending triggers
    chk_off_idle: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !st.tb[0].ctrl[15] |=> secondary_master_counter == 16'h0000)
        else $error("counter moved while disabled");
    chk_off_post: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !st.tb[0].ctrl[15] |=> st.tb[0].post == 4'h0 && !primary_trigger)
        else $error("postscaler ran while disabled");

    // divide by two: a tick is never followed by another one
    chk_ptick_gap: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        tick[0] && st.tb[0].div == 3'h1 |=> !tick[0])
        else $error("divide by two ticked twice in a row");

    // postscalers: only matches move them, the last match of a group fires
    chk_ps_one: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        match[0] && st.tb[0].ctrl[3:0] == 4'h0 |=> primary_trigger)
        else $error("1:1 postscale missed trigger");
    chk_ptrig_cause: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        primary_trigger |-> $past(match[0]))
        else $error("primary trigger without match");
    chk_post_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.tb[0].ctrl[15] && !match[0] |=> st.tb[0].post == $past(st.tb[0].post))
        else $error("postscaler moved without a match");
    chk_ps_one_sec: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        match[1] && st.tb[1].ctrl[3:0] == 4'h0 |=> secondary_trigger)
        else $error("secondary 1:1 postscale missed trigger");
    chk_strig_cause: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        secondary_trigger |-> $past(match[1]))
        else $error("secondary trigger without match");

    // pending flag, hardware owned, and its interrupt gated by the software enable bit
    chk_pend_set: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        secondary_trigger |-> st.pend)
        else $error("pending flag not set");
    chk_pend_clear: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !st.tb[1].ctrl[11] && !(reg_wr && reg_addr == pmtb_pkg::STB_CTRL_OFS)
        |=> !st.pend || secondary_trigger)
        else $error("pending flag kept while disabled");
    chk_irq_gate: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !st.tb[1].ctrl[11] |-> !secondary_irq)
        else $error("irq passed while disabled");
    chk_irq_follow: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.pend && st.tb[1].ctrl[11] |-> secondary_irq)
        else $error("irq missing while pending");

    // active periods: immediate on write, otherwise only at a wrap
    chk_imm_upd: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        reg_wr && reg_addr == 4'h6 && st.tb[1].ctrl[10] |=> st.tb[1].per_act == $past(reg_wdata))
        else $error("immediate period update missed");
    chk_sper_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !st.tb[1].ctrl[10] && !wrap[1] |=> st.tb[1].per_act == $past(st.tb[1].per_act))
        else $error("secondary period changed mid cycle");
    chk_pri_upd_now: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        reg_wr && reg_addr == pmtb_pkg::PTB_PER_OFS && st.tb[0].ctrl[10]
        |=> st.tb[0].per_act == $past(reg_wdata))
        else $error("primary immediate period update missed");
    chk_pper_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !st.tb[0].ctrl[10] && !wrap[0] |=> st.tb[0].per_act == $past(st.tb[0].per_act))
        else $error("primary period changed mid cycle");

    // external sync: restart on edge, ignored when off, reserved source selects nothing
    chk_sync_rst: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        sync_hit[1] && st.tb[0].ctrl[15] |=> secondary_master_counter == 16'h0000)
        else $error("sync did not restart counter");
    chk_sync_ignored: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.tb[0].ctrl[15] && !st.tb[1].ctrl[7] && !tick[1]
        |=> secondary_master_counter == $past(secondary_master_counter))
        else $error("secondary counter moved without a tick");
    chk_src_reserved: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.tb[1].ctrl[6] |-> !sel_now[1])
        else $error("reserved sync source selected a line");

    // sync outputs: idle at the polarity bit, one inverted clock at wrap
    chk_sout_off: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !$past(st.tb[1].ctrl[8]) |-> secondary_sync_out == $past(st.tb[1].ctrl[9]))
        else $error("sync out active while disabled");
    chk_ssout_pulse: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.tb[1].ctrl[8] && wrap[1] |=> secondary_sync_out != $past(st.tb[1].ctrl[9]))
        else $error("secondary sync out missed a wrap");
    chk_psout_pulse: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.tb[0].ctrl[8] && wrap[0] |=> primary_sync_out != $past(st.tb[0].ctrl[9]))
        else $error("primary sync out missed a wrap");

    // chop clock: stopped when off, moves only on primary ticks
    chk_chop_off: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !st.chop[15] |=> !chop_clk)
        else $error("chop ran while disabled");
    chk_chop_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.chop[15] && st.tb[0].ctrl[15] && !tick[0] |=> $stable(chop_clk))
        else $error("chop moved without a primary tick");
    chk_chop_toggle: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        st.chop[15] && st.tb[0].ctrl[15] && tick[0] && st.chop_cnt == chop_lim
        |=> chop_clk != $past(chop_clk))
        else $error("chop missed its half period");
endmodule : pmtb_core

// *** tb/pmtb_sync_source.sv ***
// partner model: external source for the four sync inputs
module pmtb_sync_source #(
    parameter int HOLD = 4
) (
    input  wire logic       sys_clk,
    input  wire logic       pol,
    input  wire logic [3:0] fire,
    output logic      [3:0] sync_input_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] act = 4'h0;
    int         left = 0;
    // hold a fired line active for a few clocks, the others stay idle
    always @(posedge sys_clk) begin
        if (fire != 4'h0) begin
            act  <= fire;
            left <= HOLD;
        end else if (left > 1) begin
            left <= left - 1;
        end else begin
            act <= 4'h0;
        end
    end
    // idle level is the inactive one, so each pulse gives one clean edge
    assign sync_input_n = pol ? ~act : act;
endmodule : pmtb_sync_source

// *** tb/pmtb_core_test.sv ***
// testbench: register port, trigger spacing, chop clock, sync and period updates
module pmtb_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, arst_n, reg_wr, reg_rd, pol;
    logic        pt, st, irq, chop, pso, sso;
    logic [3:0]  reg_addr, fire, sync_input_n, ps;
    logic [15:0] reg_wdata, reg_rdata, pmc, smc, d;
    logic [2:0]  dv;
    int          n_errors = 0, n_compared = 0, seed = 62;
    int          n, i, j, r, s;
    int          ra[8] = '{2, 6, 1, 5, 3, 7, 8, 11};
    logic [15:0] re[8] = '{16'hFFF8, 16'hFFF8, 16'h0000, 16'h0000,
                           16'hFFF8, 16'hFFF8, 16'h83F8, 16'h0000};

    always #12.5 sys_clk = ~sys_clk;

    pmtb_core dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sync_input_n(sync_input_n), .primary_sync_out(pso), .secondary_sync_out(sso),
        .primary_trigger(pt), .secondary_trigger(st), .secondary_irq(irq),
        .chop_clk(chop), .primary_master_counter(pmc), .secondary_master_counter(smc));
    pmtb_sync_source #(.HOLD(4)) src (.sys_clk(sys_clk), .pol(pol), .fire(fire),
        .sync_input_n(sync_input_n));

    // comparison with a one-line report on mismatch
    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // register port: one-cycle strobes, read data in the following cycle
    task automatic wr(input int a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr  <= 4'(a);
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input int a, output logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= 4'(a);
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // observable events, picked by number so one wait loop serves all
    function automatic logic ev(input int k);
        logic [15:0] c;
        c = k[0] ? smc : pmc;
        case (k)
            0: return pt;
            1: return st;
            2: return chop;
            3: return ~chop;
            4: return pso ^ pol;
            5: return sso ^ pol;
            6, 7: return c == 16'h0020;
            default: return c == 16'h0000;
        endcase
    endfunction : ev

    // bounded wait; n holds the cycles spent, a required event that never comes ends the run
    task automatic wt(input int k, lim, input bit must);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (ev(k) !== 1'b1 && n < lim);
        if (must && n >= lim) begin
            n_errors++;
            $display("mismatch at %0t: wait %0d ran out", $time, k);
            stop_test();
        end
    endtask : wt

    // expected spacing in clocks: ticks per event scaled by the divider
    function automatic logic [15:0] span(input int base, mul, input logic [2:0] dv);
        return 16'((base * mul) << dv);
    endfunction : span

    // settings change only with the module off, then it is switched on
    task automatic cfg(input int s, input logic [2:0] dv, input logic [15:0] p, c, ct);
        // immediate update while off, so the new period is active from the first tick
        wr(pmtb_pkg::PTB_CTRL_OFS, 16'h0400);
        wr(pmtb_pkg::STB_CTRL_OFS, 16'h0400);
        wr(pmtb_pkg::PTB_DIV_OFS + 4 * s, {13'h0, dv});
        wr(pmtb_pkg::PTB_PER_OFS + 4 * s, p);
        wr(pmtb_pkg::PTB_CMP_OFS + 4 * s, c);
        if (s == 1) wr(pmtb_pkg::STB_CTRL_OFS, ct);
        wr(pmtb_pkg::PTB_CTRL_OFS, 16'h8000 | (s == 1 ? 16'h0000 : ct));
    endtask : cfg

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    initial begin
        sys_clk   = 1'b0;
        arst_n    = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
        pol       = 1'b0;
        fire      = 4'h0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        // reset values, unimplemented bits and an unmapped index
        for (i = 0; i < 8; i++) begin
            if (i > 3) wr(ra[i], 16'hFFFF);
            rd(ra[i], d);
            chk(d, re[i]);
        end
        // trigger spacing over divider codes 0 to 6 and the postscale corners
        for (s = 0; s < 2; s++)
            for (i = 0; i < 10; i++) begin
                dv = (i < 7) ? 3'(i) : 3'h0;
                ps = (i == 7) ? 4'h1 : (i == 8) ? 4'hF : (i == 9) ? 4'($random(seed)) : 4'h0;
                cfg(s, dv, 16'h0010, 16'h0008, {12'h0, ps});
                wt(s, 2000, 1);
                wt(s, 20000, 1);
                chk(16'(n), span(16'h0010 + 1, int'(ps) + 1, dv));
            end
        // reserved divider code never ticks, so the counter stays at zero
        cfg(0, 3'h7, 16'h0010, 16'h0008, 16'h0000);
        repeat (20) @(posedge sys_clk);
        #1 chk(pmc, 16'h0000);
        // chop high time follows the primary divider, not the secondary one
        for (i = 0; i < 3; i++) begin
            dv = 3'($random(seed) & 3);
            r = (i == 0) ? 0 : (i == 1) ? 127 : ($random(seed) & 127);
            cfg(1, dv ^ 3'h1, 16'h0010, 16'h0008, 16'h0000);
            cfg(0, dv, 16'h0010, 16'h0008, 16'h0000);
            wr(pmtb_pkg::CHOP_OFS, 16'h8000 | 16'(r << 3));
            wt(3, 9000, 1);
            wt(2, 9000, 1);
            wt(3, 9000, 1);
            chk(16'(n), span(8, r + 1, dv));
        end
        wr(pmtb_pkg::CHOP_OFS, 16'h0000);
        repeat (2) @(posedge sys_clk);
        wt(2, 40, 0);
        chk(16'(n), 16'h0028);
        // only the selected line restarts the counter, and only when enabled
        for (i = 0; i < 15; i++) begin
            j = i % 3;
            r = i / 3;
            pol <= 1'($random(seed));
            repeat (4) @(posedge sys_clk);
            cfg(1, 3'h0, 16'hFFF8, 16'h0000, 16'(pol) << 9 | 16'(j != 1) << 7 | 16'(r) << 4);
            repeat (40) @(posedge sys_clk);
            fire <= 4'h1 << (j == 0 ? (r + 1) % 4 : r % 4);
            @(posedge sys_clk);
            fire <= 4'h0;
            repeat (12) @(posedge sys_clk);
            #1 chk(16'(smc < 16'h0020), 16'(j == 2 && r < 4));
        end
        // sync output pulses only when enabled; idle level is the polarity bit
        for (i = 0; i < 8; i++) begin
            pol <= 1'((i >> 1) & 1);
            cfg(i % 2, 3'h0, 16'h0010, 16'h0008, 16'((i >> 1) & 1) << 9 | 16'(i < 4) << 8);
            wt(4 + i % 2, 40, 0);
            chk(16'(n < 40), 16'(i < 4));
        end
        // pending flag is hardware owned, interrupt gated by its enable
        for (i = 0; i < 2; i++) begin
            cfg(1, 3'h0, 16'h0010, 16'h0008, i ? 16'h0800 : 16'h1000);
            wt(1, 40, 1);
            repeat (2) @(posedge sys_clk);
            #1 chk(16'(irq), 16'(i));
            rd(pmtb_pkg::STB_CTRL_OFS, d);
            chk(d, i ? 16'h1800 : 16'h0000);
        end
        // shortened period applies at once or only after the next wrap
        for (i = 0; i < 4; i++) begin
            cfg(i % 2, 3'h0, 16'h0040, 16'h0008, 16'(i >> 1) << 10);
            wt(6 + i % 2, 200, 1);
            wr(pmtb_pkg::PTB_PER_OFS + 4 * (i % 2), 16'h0010);
            wt(8 + i % 2, 200, 1);
            chk(16'(n < 12), 16'(i >> 1));
        end
        // switching the module off stops and clears both counters
        wr(pmtb_pkg::PTB_CTRL_OFS, 16'h0000);
        repeat (3) @(posedge sys_clk);
        #1 chk(pmc | smc, 16'h0000);
        stop_test();
    end
endmodule : pmtb_core_test
